// ===== inc/cpm_pkg.sv
// Package with mode, pin group, address and reset constants for the card pin mode mapper.
package cpm_pkg;

   typedef enum logic [1:0] {
      CPM_MODE_MEM,
      CPM_MODE_IO,
      CPM_MODE_IDE
   } cpm_mode_type;

   typedef enum logic [1:0] {
      CPM_UDMA_NONE,
      CPM_UDMA_WRITE,
      CPM_UDMA_READ
   } cpm_udma_type;

   // Host-side control pins as seen at the card connector, all active levels as wired.
   typedef struct packed {
      logic       ce1_n;
      logic       ce2_n;
      logic       oe_n;
      logic       we_n;
      logic       rd_strobe;
      logic       wr_strobe;
      logic       reg_n;
      logic       csel_n;
      logic [10:0] addr;
   } cpm_host_pins_type;

   // Card-side indications from the storage core.
   typedef struct packed {
      logic ready;
      logic irq;
      logic dma_req;
      logic in_ack;
      logic wait_req;
      logic dev_dmardy;
      logic dev_strobe;
      logic io16;
   } cpm_core_sig_type;

   // Decoded access presented to the storage core.
   typedef struct packed {
      logic       valid;
      logic       rd;
      logic       wr;
      logic       wide;
      logic       attr;
      logic       dma_ack;
      logic       host_strobe;
      logic       host_dmardy;
      logic       stop;
      logic [10:0] addr;
   } cpm_access_type;

   localparam logic [2:0]  CPM_TASKFILE_MASK = 3'h7;
   localparam int          CPM_TASK_BITS     = 3;
   localparam logic [10:0] CPM_ADDR_RESET    = 11'h000;
   localparam logic [1:0]  CPM_MODE_PIN_MEM  = 2'h0;
   localparam logic [1:0]  CPM_MODE_PIN_IO   = 2'h1;
   // Reset levels of pins 37, 42, 43 and 24, in that order from the top bit.
   localparam logic [3:0]  CPM_PINS_RESET    = 4'h7;

endpackage

// ===== rtl/cpm_out_mux.sv
// Mode-dependent selection of the card output pin levels.
`timescale 1ns/100ps
module cpm_out_mux (
   input  wire cpm_pkg::cpm_mode_type     mode,
   input  wire cpm_pkg::cpm_udma_type     udma,
   input  wire cpm_pkg::cpm_core_sig_type core,
   output logic                           pin37,
   output logic                           pin42,
   output logic                           pin43,
   output logic                           pin24
);
   always_comb begin
      pin37 = 1'b0;
      pin42 = 1'b1;
      pin43 = 1'b1;
      pin24 = 1'b1;
      case (mode)
         cpm_pkg::CPM_MODE_MEM: begin
            pin37 = core.ready;
            pin42 = ~core.wait_req;
            pin43 = ~core.in_ack;
            pin24 = 1'b0;
         end
         cpm_pkg::CPM_MODE_IO: begin
            pin37 = ~core.irq;
            pin42 = ~core.wait_req;
            pin43 = ~core.in_ack;
            // The core's indication passes inverted, so a host may still see words split into bytes.
            pin24 = ~core.io16;
         end
         cpm_pkg::CPM_MODE_IDE: begin
            pin37 = core.irq;
            pin43 = core.dma_req;
            pin24 = ~core.io16;
            case (udma)
               cpm_pkg::CPM_UDMA_WRITE: pin42 = ~core.dev_dmardy;
               cpm_pkg::CPM_UDMA_READ:  pin42 = core.dev_strobe;
               default:                 pin42 = ~core.wait_req;
            endcase
         end
         default: begin
            pin37 = 1'b0;
         end
      endcase
   end
endmodule

// ===== rtl/cpm_pin_map.sv
// Card host pin mapper: mode selection, input decoding and registered outputs.
`timescale 1ns/100ps
module cpm_pin_map (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic                        ide_sel_n,
   input  wire logic [1:0]                  pc_mode,
   input  wire cpm_pkg::cpm_udma_type       udma,
   input  wire cpm_pkg::cpm_host_pins_type  host,
   input  wire logic                        host_hi_valid,
   input  wire cpm_pkg::cpm_core_sig_type   core,
   output logic                             csel_pullup_en,
   output logic                             hi_pullup_en,
   output cpm_pkg::cpm_mode_type            mode_out,
   output cpm_pkg::cpm_access_type          acc,
   output logic                             pin37_r,
   output logic                             pin42_r,
   output logic                             pin43_r,
   output logic                             pin24_r,
   output logic                             dev_sel_r
);

   cpm_pkg::cpm_mode_type   mode_r;
   cpm_pkg::cpm_mode_type   mode_nxt;
   logic                    latched_r;
   logic                    latched_nxt;
   cpm_pkg::cpm_access_type acc_r;
   cpm_pkg::cpm_access_type acc_nxt;
   logic                    csel_pu_r;
   logic                    csel_pu_nxt;
   logic                    dev_sel_nxt;
   logic                    m37;
   logic                    m42;
   logic                    m43;
   logic                    m24;

   function automatic logic is_pc(input cpm_pkg::cpm_mode_type m);
      is_pc = (m != cpm_pkg::CPM_MODE_IDE);
   endfunction

   // The mode is caught once after reset release, since the select strap is a level.
   always_comb begin
      mode_nxt    = mode_r;
      latched_nxt = 1'b1;
      if (!latched_r) begin
         if (!ide_sel_n) begin
            mode_nxt = cpm_pkg::CPM_MODE_IDE;
         end else if (pc_mode == cpm_pkg::CPM_MODE_PIN_IO) begin
            mode_nxt = cpm_pkg::CPM_MODE_IO;
         end else begin
            mode_nxt = cpm_pkg::CPM_MODE_MEM;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r    <= cpm_pkg::CPM_MODE_MEM;
         latched_r <= 1'b0;
      end else begin
         mode_r    <= mode_nxt;
         latched_r <= latched_nxt;
      end
   end

   // Input decode per mode.
   always_comb begin
      acc_nxt       = '0;
      acc_nxt.addr  = cpm_pkg::CPM_ADDR_RESET;
      csel_pu_nxt   = 1'b0;
      dev_sel_nxt   = 1'b0;
      if (latched_r) begin
         if (is_pc(mode_r)) begin
            csel_pu_nxt  = 1'b0;
            acc_nxt.attr = ~host.reg_n;
            // Word access only with the upper byte lines actually present.
            acc_nxt.wide = ~host.ce1_n & ~host.ce2_n & host_hi_valid;
            acc_nxt.valid = ~host.ce1_n | (~host.ce2_n & host_hi_valid);
            acc_nxt.addr = host.addr;
            if (mode_r == cpm_pkg::CPM_MODE_MEM) begin
               acc_nxt.rd = ~host.oe_n;
               acc_nxt.wr = ~host.we_n;
            end else begin
               acc_nxt.rd = ~host.rd_strobe;
               acc_nxt.wr = ~host.wr_strobe;
            end
         end else begin
            csel_pu_nxt     = 1'b1;
            dev_sel_nxt     = ~host.csel_n;
            acc_nxt.dma_ack = ~host.reg_n;
            acc_nxt.valid   = ~host.ce1_n | ~host.ce2_n;
            acc_nxt.addr    = {8'h00, host.addr[2:0] & cpm_pkg::CPM_TASKFILE_MASK};
            case (udma)
               cpm_pkg::CPM_UDMA_WRITE: begin
                  acc_nxt.host_strobe = host.rd_strobe;
                  acc_nxt.stop        = host.wr_strobe;
               end
               cpm_pkg::CPM_UDMA_READ: begin
                  acc_nxt.host_dmardy = ~host.rd_strobe;
                  acc_nxt.stop        = host.wr_strobe;
               end
               default: begin
                  acc_nxt.rd = ~host.rd_strobe;
                  acc_nxt.wr = ~host.wr_strobe;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r     <= '0;
         csel_pu_r <= 1'b0;
         dev_sel_r <= 1'b0;
      end else begin
         acc_r     <= acc_nxt;
         csel_pu_r <= csel_pu_nxt;
         dev_sel_r <= dev_sel_nxt;
      end
   end

   cpm_out_mux i_cpm_out_mux (
      .mode  (mode_r),
      .udma  (udma),
      .core  (core),
      .pin37 (m37),
      .pin42 (m42),
      .pin43 (m43),
      .pin24 (m24)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {pin37_r, pin42_r, pin43_r, pin24_r} <= cpm_pkg::CPM_PINS_RESET;
      end else begin
         pin37_r <= m37;
         pin42_r <= m42;
         pin43_r <= m43;
         pin24_r <= m24;
      end
   end

   assign csel_pullup_en = csel_pu_r;
   assign hi_pullup_en   = 1'b0;
   assign mode_out       = mode_r;
   assign acc            = acc_r;

   a_csel_ignored: assert property (@(posedge clk) disable iff (!rst_n)
      latched_r && is_pc(mode_r) |=> !csel_pullup_en && !dev_sel_r)
      else $error("cable select acted on in PC Card mode");

   a_ide_addr_lim: assert property (@(posedge clk) disable iff (!rst_n)
      latched_r && mode_r == cpm_pkg::CPM_MODE_IDE |=> acc.addr[10:3] == 8'h00)
      else $error("task file address wider than three bits");

   a_dmack_map: assert property (@(posedge clk) disable iff (!rst_n)
      latched_r && mode_r == cpm_pkg::CPM_MODE_IDE |=> acc.dma_ack == !$past(host.reg_n))
      else $error("dma acknowledge not taken from attribute select");

   a_iordy_map: assert property (@(posedge clk) disable iff (!rst_n)
      mode_r == cpm_pkg::CPM_MODE_IDE && udma == cpm_pkg::CPM_UDMA_NONE
      |=> pin42_r == !$past(core.wait_req))
      else $error("ready pin not IORDY outside burst");

   a_ddmardy_map: assert property (@(posedge clk) disable iff (!rst_n)
      mode_r == cpm_pkg::CPM_MODE_IDE && udma == cpm_pkg::CPM_UDMA_WRITE
      |=> pin42_r == !$past(core.dev_dmardy) && acc.stop == $past(host.wr_strobe))
      else $error("write burst pin mapping wrong");

   a_dstrobe_map: assert property (@(posedge clk) disable iff (!rst_n)
      mode_r == cpm_pkg::CPM_MODE_IDE && udma == cpm_pkg::CPM_UDMA_READ
      |=> pin42_r == $past(core.dev_strobe) && acc.host_dmardy == !$past(host.rd_strobe))
      else $error("read burst pin mapping wrong");

   a_irq_map: assert property (@(posedge clk) disable iff (!rst_n)
      mode_r == cpm_pkg::CPM_MODE_IO |=> pin37_r == !$past(core.irq))
      else $error("interrupt pin wrong in I/O mode");

   a_wide_needs_hi: assert property (@(posedge clk) disable iff (!rst_n)
      !host_hi_valid |=> !acc.wide)
      else $error("word access without upper byte lines");

   a_io16_pc: assert property (@(posedge clk) disable iff (!rst_n)
      mode_r == cpm_pkg::CPM_MODE_MEM |=> pin24_r == 1'b0)
      else $error("write protect pin not low in memory mode");

   a_io16_map: assert property (@(posedge clk) disable iff (!rst_n)
      mode_r == cpm_pkg::CPM_MODE_IO |=> pin24_r == !$past(core.io16))
      else $error("16-bit indication wrong in I/O mode");

   a_ide_latch: assert property (@(posedge clk) disable iff (!rst_n)
      !latched_r && !ide_sel_n |=> mode_r == cpm_pkg::CPM_MODE_IDE)
      else $error("IDE mode not entered");

endmodule

// ===== tb/cpm_host_model.sv
// Host controller model that drives the card's host-side pins.
`timescale 1ns/100ps
module cpm_host_model (
   input  wire logic                       ide_sel_n,
   input  wire cpm_pkg::cpm_host_pins_type req,
   input  wire logic                       a25,
   input  wire logic                       dma_on,
   output cpm_pkg::cpm_host_pins_type      host
);
   always_comb begin
      host = req;
      if (ide_sel_n) begin
         host.csel_n = a25;
         // Word accesses with A0 high are steered away, the card mishandles them.
         if (!req.ce1_n && !req.ce2_n) begin
            host.addr[0] = 1'b0;
         end
      end else begin
         host.we_n = 1'b1;
         if (!dma_on) begin
            host.reg_n = 1'b1;
         end
      end
   end
endmodule

// ===== tb/cpm_pin_map_tb.sv
// Self-checking testbench for the card host pin mapper.
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module cpm_pin_map_tb;
   logic                       clk;
   logic                       rst_n;
   logic                       ide_sel_n;
   logic [1:0]                 pc_mode;
   cpm_pkg::cpm_udma_type      udma;
   cpm_pkg::cpm_host_pins_type req;
   cpm_pkg::cpm_host_pins_type host;
   logic                       a25;
   logic                       dma_on;
   logic                       host_hi_valid;
   cpm_pkg::cpm_core_sig_type  core;
   logic                       csel_pullup_en;
   logic                       hi_pullup_en;
   cpm_pkg::cpm_mode_type      mode_out;
   cpm_pkg::cpm_access_type    acc;
   logic                       pin37_r;
   logic                       pin42_r;
   logic                       pin43_r;
   logic                       pin24_r;
   logic                       dev_sel_r;
   int                         err_count;
   int                         compares;

   cpm_host_model i_cpm_host_model (.ide_sel_n(ide_sel_n), .req(req), .a25(a25),
      .dma_on(dma_on), .host(host));
   cpm_pin_map i_cpm_pin_map (.clk(clk), .rst_n(rst_n), .ide_sel_n(ide_sel_n),
      .pc_mode(pc_mode), .udma(udma), .host(host), .host_hi_valid(host_hi_valid),
      .core(core), .csel_pullup_en(csel_pullup_en), .hi_pullup_en(hi_pullup_en),
      .mode_out(mode_out), .acc(acc), .pin37_r(pin37_r), .pin42_r(pin42_r),
      .pin43_r(pin43_r), .pin24_r(pin24_r), .dev_sel_r(dev_sel_r));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic report_and_stop;
      if (err_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic step;
      @(negedge clk);
   endtask

   // The mode strap is only taken after reset, so every mode needs its own reset.
   task automatic do_reset(input logic ide, input logic [1:0] pm);
      rst_n = 1'b0;
      ide_sel_n = ide;
      pc_mode = pm;
      repeat (10) step;
      `CHK({pin37_r, pin42_r, pin43_r, pin24_r}, 4'h7)
      `CHK(acc, cpm_pkg::cpm_access_type'(0))
      rst_n = 1'b1;
      repeat (3) step;
   endtask

   task automatic t_mem;
      do_reset(1'b1, cpm_pkg::CPM_MODE_PIN_MEM);
      `CHK(mode_out, cpm_pkg::CPM_MODE_MEM)
      core.ready = 1'b1;
      core.in_ack = 1'b1;
      a25 = 1'b0;
      step;
      `CHK(pin37_r, 1'b1)
      `CHK(pin43_r, 1'b0)
      `CHK(dev_sel_r, 1'b0)
      `CHK(csel_pullup_en, 1'b0)
      `CHK(hi_pullup_en, 1'b0)
      core = '0;
      a25 = 1'b1;
      step;
      `CHK(pin37_r, 1'b0)
      `CHK(pin43_r, 1'b1)
      `CHK(dev_sel_r, 1'b0)
   endtask

   task automatic t_io;
      do_reset(1'b1, cpm_pkg::CPM_MODE_PIN_IO);
      `CHK(mode_out, cpm_pkg::CPM_MODE_IO)
      core.irq = 1'b1;
      host_hi_valid = 1'b0;
      req.ce1_n = 1'b0;
      req.ce2_n = 1'b0;
      step;
      `CHK(pin37_r, 1'b0)
      `CHK(acc.wide, 1'b0)
      core.irq = 1'b0;
      core.io16 = 1'b1;
      host_hi_valid = 1'b1;
      step;
      `CHK(pin37_r, 1'b1)
      `CHK(pin24_r, 1'b0)
      `CHK(acc.wide, 1'b1)
      core.io16 = 1'b0;
      req = '1;
   endtask

   task automatic t_ide;
      do_reset(1'b0, 2'h0);
      `CHK(mode_out, cpm_pkg::CPM_MODE_IDE)
      `CHK(csel_pullup_en, 1'b1)
      dma_on = 1'b1;
      req.reg_n = 1'b0;
      req.csel_n = 1'b0;
      req.addr = 11'h7fd;
      req.rd_strobe = 1'b0;
      core.irq = 1'b1;
      core.dma_req = 1'b1;
      core.wait_req = 1'b1;
      step;
      `CHK(acc.addr, 11'h005)
      `CHK(acc.dma_ack, 1'b1)
      `CHK(dev_sel_r, 1'b1)
      `CHK({pin37_r, pin43_r}, 2'h3)
      `CHK(pin42_r, 1'b0)
      `CHK({acc.rd, acc.wr}, 2'h2)
      core = '0;
      req.csel_n = 1'b1;
      req.rd_strobe = 1'b1;
      req.wr_strobe = 1'b0;
      dma_on = 1'b0;
      step;
      `CHK(acc.dma_ack, 1'b0)
      `CHK(dev_sel_r, 1'b0)
      `CHK({pin37_r, pin43_r}, 2'h0)
      `CHK(pin42_r, 1'b1)
      `CHK({acc.rd, acc.wr}, 2'h1)
   endtask

   task automatic t_udma;
      udma = cpm_pkg::CPM_UDMA_WRITE;
      core.dev_dmardy = 1'b1;
      req.rd_strobe = 1'b1;
      req.wr_strobe = 1'b1;
      step;
      `CHK(pin42_r, 1'b0)
      `CHK({acc.host_strobe, acc.stop}, 2'h3)
      udma = cpm_pkg::CPM_UDMA_READ;
      core.dev_dmardy = 1'b0;
      core.dev_strobe = 1'b1;
      req.rd_strobe = 1'b0;
      req.wr_strobe = 1'b0;
      step;
      `CHK(pin42_r, 1'b1)
      `CHK({acc.host_dmardy, acc.stop}, 2'h2)
      core.dev_strobe = 1'b0;
      step;
      `CHK(pin42_r, 1'b0)
   endtask

   initial begin
      err_count = 0;
      compares = 0;
      rst_n = 1'b0;
      ide_sel_n = 1'b1;
      pc_mode = 2'h0;
      udma = cpm_pkg::CPM_UDMA_NONE;
      req = '1;
      a25 = 1'b0;
      dma_on = 1'b0;
      host_hi_valid = 1'b1;
      core = '0;
      t_mem;
      t_io;
      t_ide;
      t_udma;
      report_and_stop;
   end

   // The tests need well under 200 cycles; this only catches a hang.
   initial begin
      repeat (2000) @(posedge clk);
      err_count++;
      report_and_stop;
   end
endmodule
